/* connector_wiring.sv */
`timescale 1ns/1ps
// far side of the connector: an external level on input a and a cable
// looping output b back to input b, so one test sees a real round trip
module connector_wiring
(
	// connector output of the camera
	input  wire logic output_line_b,
	// level of the external source
	input  wire logic ext_level_a,
	// connector inputs of the camera
	output logic      input_pin_a,
	output logic      input_pin_b
);
	// plain wires, the pins always have a driver so no float to model
	assign input_pin_a = ext_level_a;
	assign input_pin_b = output_line_b;
endmodule

/* line_pkg.sv */
package line_pkg;

	// line picker codes
	localparam logic [1:0] PICK_INPUT_A  = 2'h0;
	localparam logic [1:0] PICK_INPUT_B  = 2'h1;
	localparam logic [1:0] PICK_OUTPUT_A = 2'h2;
	localparam logic [1:0] PICK_OUTPUT_B = 2'h3;

	// output source codes
	localparam logic [3:0] SRC_OFF       = 4'h0;
	localparam logic [3:0] SRC_EXP_BEGIN = 4'h1;
	localparam logic [3:0] SRC_EXP_END   = 4'h2;
	localparam logic [3:0] SRC_EXP_MID   = 4'h3;
	localparam logic [3:0] SRC_EXP_WIN   = 4'h4;
	localparam logic [3:0] SRC_TRIG_RAW  = 4'h5;
	localparam logic [3:0] SRC_TRIG_DLY  = 4'h6;
	localparam logic [3:0] SRC_GENERATOR = 4'h7;
	localparam logic [3:0] SRC_FLASH_A   = 4'h8;
	localparam logic [3:0] SRC_FLASH_B   = 4'h9;
	localparam logic [3:0] SRC_LAST      = 4'h9;

	// generator run styles
	localparam logic       STYLE_CONTINUOUS = 1'b0;
	localparam logic       STYLE_COUNTED    = 1'b1;

	// reset values of the settings
	localparam logic [3:0] SRC_RESET        = 4'h0;
	localparam logic [1:0] SCALE_RESET      = 2'h0;

	// time base: microsecond tick derived from the clock
	localparam int         CLK_MHZ          = 100;
	localparam int         TICK_US          = 1;
	localparam int         CYCLES_PER_US    = CLK_MHZ * TICK_US;
	localparam int         SCALE_FACTOR_1   = 1;
	localparam int         SCALE_FACTOR_10  = 10;
	localparam int         SCALE_FACTOR_100 = 100;
	localparam int         SCALE_FACTOR_1K  = 1000;

	// internal camera events feeding the output mux
	typedef struct packed {
		logic exposure_begin_pulse;
		logic exposure_finish_pulse;
		logic exposure_midpoint_pulse;
		logic exposure_window_level;
		logic raw_trigger_pass;
		logic delayed_trigger_pass;
		logic flash_pulse_a;
		logic flash_pulse_b;
	} event_bus_t;

	// generator settings
	typedef struct packed {
		logic [1:0]  tick_scale;
		logic [31:0] pulse_high_len;
		logic [31:0] pulse_cycle_len;
		logic [16:0] burst_count;
		logic        generator_run_style;
		logic        generator_on;
	} gen_cfg_t;

	// per-output-line settings
	typedef struct packed {
		logic [3:0] output_signal_select;
		logic       polarity_flip;
	} out_cfg_t;

endpackage

/* output_line_select_pulse_gen.sv */
`timescale 1ns/1ps
// Functional notes
// [R1] exposure-begin source gives a short pulse at each exposure start
// [R2] exposure-finish source gives a short pulse at each exposure end
// [R3] midpoint source gives a short pulse at mid exposure
// [R4] exposure-window source is high for the whole exposure
// [R5] raw trigger passes to the output with no added delay; the code registers it, so it arrives one clock cycle later
// [R6] delayed trigger passes to the output after the trigger delay
// [R7] generator source routes the generator waveform unchanged
// [R8] flash sources route strobe a or strobe b
// [R9] inversion on all four lines; source select on outputs only
// [R10] software reads the level of the picked line
// [R11] direction indicator tells input or output for the picked line
// [R12] time base codes 0..3 give 1, 10, 100, 1000 us ticks
// [R13] pulse stays high for the width count in ticks
// [R14] pulses repeat at the period count in ticks
// [R15] burst length from 1 to 65536 pulses
// [R16] run style 0 continuous, 1 counted burst
// [R17] pulses only while enabled; generator usable by outputs and trigger
// [R18] source codes 0 off through 9 second strobe
// [R19] picker codes 0,1 inputs and 2,3 outputs; picker steers controls
// [R20] counted burst stops after its count, rearms on a new enable
// [R21] an off output sits at its inactive level after inversion
module output_line_select_pulse_gen
	import line_pkg::*;
#(
	parameter int CYCLES = CYCLES_PER_US
)(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// internal camera events, same clock domain
	input  wire event_bus_t events,
	// connector inputs, asynchronous
	input  wire logic       input_pin_a,
	input  wire logic       input_pin_b,
	// per-line controls addressed through the picker
	input  wire logic [1:0] line_pick,
	input  wire logic       polarity_flip,
	input  wire logic       polarity_write,
	input  wire logic [3:0] output_signal_select,
	input  wire logic       select_write,
	// generator settings
	input  wire logic [1:0] tick_scale,
	input  wire logic [31:0] pulse_high_len,
	input  wire logic [31:0] pulse_cycle_len,
	input  wire logic [16:0] burst_count,
	input  wire logic       generator_run_style,
	input  wire logic       generator_on,
	// connector outputs
	output logic            output_line_a,
	output logic            output_line_b,
	// conditioned inputs for the trigger logic
	output logic            input_line_a,
	output logic            input_line_b,
	// generator as trigger source
	output logic            generator_trigger,
	output logic            generator_running,
	// readback
	output logic            level_readback,
	output logic            direction_indicator,
	output logic            polarity_readback,
	output logic [3:0]      select_readback
);

	initial if (CYCLES < 1) $error("output_line_select_pulse_gen: CYCLES must be positive");

	logic [1:0]  in_meta;
	logic [1:0]  in_sync;
	logic [1:0]  in_flip;
	out_cfg_t    out_cfg [2];
	gen_cfg_t    gcfg;
	logic        tick;
	logic        gen_wave;
	logic [1:0]  next_out;
	logic [1:0]  raw_src;

	// generator settings bundle
	assign gcfg = '{tick_scale:          tick_scale,
	                pulse_high_len:      pulse_high_len,
	                pulse_cycle_len:     pulse_cycle_len,
	                burst_count:         burst_count,
	                generator_run_style: generator_run_style,
	                generator_on:        generator_on};

	tick_divider #(
		.CYCLES     (CYCLES)
	) u_tick (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.tick_scale (tick_scale),
		.tick       (tick)
	);

	pulse_engine u_gen (
		.clk     (clk),
		.sys_rst (sys_rst),
		.cfg     (gcfg),
		.tick    (tick),
		.wave    (gen_wave),
		.running (generator_running)
	);

	// two-stage synchroniser on connector inputs
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			in_meta <= '0;
			in_sync <= '0;
		end
		else
		begin
			in_meta <= {input_pin_b, input_pin_a};
			in_sync <= in_meta;
		end
	end

	// per-line settings, written through the picker
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			in_flip <= '0;
			for (int i = 0; i < 2; i++)
				out_cfg[i] <= '{output_signal_select: SRC_RESET, polarity_flip: 1'b0};
		end
		else
		begin
			if (polarity_write)
			begin
				case (line_pick) // [R19]
					PICK_INPUT_A:  in_flip[0] <= polarity_flip; // [R9]
					PICK_INPUT_B:  in_flip[1] <= polarity_flip; // [R9]
					PICK_OUTPUT_A: out_cfg[0].polarity_flip <= polarity_flip; // [R9]
					PICK_OUTPUT_B: out_cfg[1].polarity_flip <= polarity_flip; // [R9]
					default:       in_flip <= in_flip;
				endcase
			end
			// source select ignored for inputs and out-of-range codes
			if (select_write && line_pick[1] && output_signal_select <= SRC_LAST) // [R9] [R18]
				out_cfg[line_pick[0]].output_signal_select <= output_signal_select;
		end
	end

	// source mux; every source is registered once, so all share one cycle of latency
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			case (out_cfg[i].output_signal_select) // [R18]
				SRC_OFF:       raw_src[i] = 1'b0; // [R21]
				SRC_EXP_BEGIN: raw_src[i] = events.exposure_begin_pulse; // [R1]
				SRC_EXP_END:   raw_src[i] = events.exposure_finish_pulse; // [R2]
				SRC_EXP_MID:   raw_src[i] = events.exposure_midpoint_pulse; // [R3]
				SRC_EXP_WIN:   raw_src[i] = events.exposure_window_level; // [R4]
				SRC_TRIG_RAW:  raw_src[i] = events.raw_trigger_pass; // [R5]
				SRC_TRIG_DLY:  raw_src[i] = events.delayed_trigger_pass; // [R6]
				SRC_GENERATOR: raw_src[i] = gen_wave; // [R7]
				SRC_FLASH_A:   raw_src[i] = events.flash_pulse_a; // [R8]
				SRC_FLASH_B:   raw_src[i] = events.flash_pulse_b; // [R8]
				default:       raw_src[i] = 1'b0;
			endcase
			next_out[i] = raw_src[i] ^ out_cfg[i].polarity_flip; // [R21]
		end
	end

	// registered line drivers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			output_line_a     <= 1'b0;
			output_line_b     <= 1'b0;
			input_line_a      <= 1'b0;
			input_line_b      <= 1'b0;
			generator_trigger <= 1'b0;
		end
		else
		begin
			output_line_a     <= next_out[0];
			output_line_b     <= next_out[1];
			input_line_a      <= in_sync[0] ^ in_flip[0]; // [R9]
			input_line_b      <= in_sync[1] ^ in_flip[1]; // [R9]
			generator_trigger <= gen_wave; // [R17]
		end
	end

	// readback of the picked line
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			level_readback      <= 1'b0;
			direction_indicator <= 1'b0;
			polarity_readback   <= 1'b0;
			select_readback     <= SRC_RESET;
		end
		else
		begin
			direction_indicator <= line_pick[1]; // [R11]
			case (line_pick) // [R19]
				PICK_INPUT_A:
				begin
					level_readback    <= input_line_a; // [R10]
					polarity_readback <= in_flip[0];
					select_readback   <= SRC_OFF;
				end
				PICK_INPUT_B:
				begin
					level_readback    <= input_line_b; // [R10]
					polarity_readback <= in_flip[1];
					select_readback   <= SRC_OFF;
				end
				PICK_OUTPUT_A:
				begin
					level_readback    <= output_line_a; // [R10]
					polarity_readback <= out_cfg[0].polarity_flip;
					select_readback   <= out_cfg[0].output_signal_select;
				end
				default:
				begin
					level_readback    <= output_line_b; // [R10]
					polarity_readback <= out_cfg[1].polarity_flip;
					select_readback   <= out_cfg[1].output_signal_select;
				end
			endcase
		end
	end

	// named steps for the mux path
	sequence begin_chosen_s;
		out_cfg[0].output_signal_select == SRC_EXP_BEGIN && !out_cfg[0].polarity_flip;
	endsequence
	sequence begin_fires_s;
		events.exposure_begin_pulse;
	endsequence

	begin_route_a: assert property (@(posedge clk) disable iff (sys_rst)
		begin_chosen_s and begin_fires_s |=> output_line_a) // [R1]
		else $error("exposure begin pulse missing on line a");
	window_route_a: assert property (@(posedge clk) disable iff (sys_rst)
		out_cfg[1].output_signal_select == SRC_EXP_WIN
		|=> output_line_b == ($past(events.exposure_window_level)
		^ $past(out_cfg[1].polarity_flip))) // [R4]
		else $error("exposure window level wrong on line b");
	raw_trig_a: assert property (@(posedge clk) disable iff (sys_rst)
		out_cfg[0].output_signal_select == SRC_TRIG_RAW
		|=> output_line_a == ($past(events.raw_trigger_pass) ^ $past(out_cfg[0].polarity_flip))) // [R5]
		else $error("raw trigger not passed within one cycle");
	gen_route_a: assert property (@(posedge clk) disable iff (sys_rst)
		out_cfg[1].output_signal_select == SRC_GENERATOR
		|=> output_line_b == ($past(gen_wave) ^ $past(out_cfg[1].polarity_flip))) // [R7]
		else $error("generator waveform not on line b");
	off_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
		out_cfg[0].output_signal_select == SRC_OFF [*2] |-> output_line_a == $past(out_cfg[0].polarity_flip)) // [R21]
		else $error("off line not at inactive level");
	direction_a: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |=> direction_indicator == $past(line_pick[1])) // [R11]
		else $error("direction indicator does not follow picker");
	input_sync_a: assert property (@(posedge clk) disable iff (sys_rst)
		in_flip[0] == 1'b0 [*4] |-> input_line_a == $past(input_pin_a, 3)) // [R9]
		else $error("input line a not three cycles behind its pin");
	flash_route_a: assert property (@(posedge clk) disable iff (sys_rst)
		out_cfg[0].output_signal_select == SRC_FLASH_B
		|=> output_line_a == ($past(events.flash_pulse_b) ^ $past(out_cfg[0].polarity_flip))) // [R8]
		else $error("second strobe not routed to line a");

endmodule

/* pulse_engine.sv */
`timescale 1ns/1ps
module pulse_engine
	import line_pkg::*;
(
	// clock and reset
	input  wire logic     clk,
	input  wire logic     sys_rst,
	// settings and time base
	input  wire gen_cfg_t cfg,
	input  wire logic     tick,
	// waveform
	output logic          wave,
	output logic          running
);

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_RUN   = 2'b01,
		ST_DONE  = 2'b11
	} gen_state_t;

	gen_state_t  state;
	logic [31:0] phase;
	logic [16:0] emitted;
	logic        on_d;
	logic        end_of_period;

	assign end_of_period = tick && (phase + 32'h1 >= cfg.pulse_cycle_len);

	// run control: counted bursts stop and rearm on a new enable edge
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state   <= ST_IDLE;
			on_d    <= 1'b0;
			emitted <= '0;
		end
		else
		begin
			on_d <= cfg.generator_on;
			case (state)
				ST_IDLE:
					if (cfg.generator_on && !on_d) // [R17]
					begin
						state   <= ST_RUN;
						emitted <= '0;
					end
				ST_RUN:
					if (!cfg.generator_on)
						state <= ST_IDLE; // [R17]
					else if (end_of_period)
					begin
						emitted <= emitted + 17'h1;
						if (cfg.generator_run_style == STYLE_COUNTED &&
						    emitted + 17'h1 >= cfg.burst_count) // [R15] [R16]
							state <= ST_DONE; // [R20]
					end
				ST_DONE:
					if (!cfg.generator_on)
						state <= ST_IDLE; // [R20]
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// phase counter in ticks, restarting every period
	always_ff @(posedge clk)
	begin
		if (sys_rst || state != ST_RUN)
			phase <= '0;
		else if (end_of_period)
			phase <= '0; // [R14]
		else if (tick)
			phase <= phase + 32'h1;
	end

	// high while phase below width; one count is one tick
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wave    <= 1'b0;
			running <= 1'b0;
		end
		else
		begin
			wave    <= (state == ST_RUN) && cfg.generator_on && (phase < cfg.pulse_high_len); // [R13]
			running <= (state == ST_RUN);
		end
	end

	done_holds_a: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_DONE && cfg.generator_on) |=> !wave) // [R20]
		else $error("generator pulsed after burst finished");
	off_silent_a: assert property (@(posedge clk) disable iff (sys_rst)
		!cfg.generator_on |=> !wave) // [R17]
		else $error("generator pulsed while disabled");
	period_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_RUN && end_of_period) |=> phase == 32'h0) // [R14]
		else $error("phase did not restart at period end");

endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
	import line_pkg::*;
	// one clock per microsecond keeps the 1000 us scale short
	localparam int CYC = 1;
	logic        clk, sys_rst, ext_level_a, input_pin_a, input_pin_b;
	event_bus_t  events;
	logic [1:0]  line_pick, tick_scale;
	logic        polarity_flip, polarity_write, select_write;
	logic [3:0]  output_signal_select, select_readback;
	logic [31:0] pulse_high_len, pulse_cycle_len;
	logic [16:0] burst_count;
	logic        generator_run_style, generator_on;
	logic        output_line_a, output_line_b, input_line_a, input_line_b;
	logic        generator_trigger, generator_running;
	logic        level_readback, direction_indicator, polarity_readback;
	int          error_cnt, num_checks, rises, highs, out_rises, run_len, gap;

	output_line_select_pulse_gen #(.CYCLES(CYC)) i_output_line_select_pulse_gen (
		.clk(clk), .sys_rst(sys_rst), .events(events),
		.input_pin_a(input_pin_a), .input_pin_b(input_pin_b),
		.line_pick(line_pick), .polarity_flip(polarity_flip),
		.polarity_write(polarity_write), .output_signal_select(output_signal_select),
		.select_write(select_write), .tick_scale(tick_scale),
		.pulse_high_len(pulse_high_len), .pulse_cycle_len(pulse_cycle_len),
		.burst_count(burst_count), .generator_run_style(generator_run_style),
		.generator_on(generator_on), .output_line_a(output_line_a),
		.output_line_b(output_line_b), .input_line_a(input_line_a),
		.input_line_b(input_line_b), .generator_trigger(generator_trigger),
		.generator_running(generator_running), .level_readback(level_readback),
		.direction_indicator(direction_indicator),
		.polarity_readback(polarity_readback), .select_readback(select_readback));

	connector_wiring i_connector_wiring (
		.output_line_b(output_line_b), .ext_level_a(ext_level_a),
		.input_pin_a(input_pin_a), .input_pin_b(input_pin_b));

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// wait n edges, then step past them so outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// one write of source and inversion to the picked line
	task automatic set_line(input logic [1:0] p, input logic [3:0] s, input logic f);
		@(posedge clk);
		line_pick <= p;
		output_signal_select <= s;
		polarity_flip <= f;
		select_write <= 1'b1;
		polarity_write <= 1'b1;
		@(posedge clk);
		select_write <= 1'b0;
		polarity_write <= 1'b0;
		cyc(3);
	endtask

	// settle with the generator off long enough for any scale to wrap
	task automatic gen_start(input logic [1:0] sc, input int w, input int p, input int b,
		input logic st);
		@(posedge clk);
		generator_on <= 1'b0;
		tick_scale <= sc;
		pulse_high_len <= 32'(w);
		pulse_cycle_len <= 32'(p);
		burst_count <= 17'(b);
		generator_run_style <= st;
		cyc(1010);
		@(posedge clk);
		generator_on <= 1'b1;
	endtask

	// bounded watch of the generator and of output a
	task automatic measure(input int n);
		int  t, last;
		logic pg, po;
		rises = 0; highs = 0; out_rises = 0; run_len = 0; gap = 0;
		t = 0; last = 0; pg = 1'b0; po = 1'b0;
		repeat (n)
		begin
			cyc(1);
			t++;
			if (generator_trigger === 1'b1)
			begin
				highs++;
				run_len = pg ? run_len + 1 : 1;
				if (!pg)
				begin
					gap = t - last;
					last = t;
					rises++;
				end
			end
			if (output_line_a === 1'b1 && !po)
				out_rises++;
			pg = (generator_trigger === 1'b1);
			po = (output_line_a === 1'b1);
		end
	endtask

	// a hang ends the run as a failure
	initial
	begin
		#1000000;
		chk("run time limit", 0, 1);
		final_report();
	end

	initial
	begin
		logic [7:0] m;
		int f;
		error_cnt = 0; num_checks = 0; sys_rst = 1'b1; events = '0; ext_level_a = 1'b0;
		line_pick = 2'h0; tick_scale = 2'h0; polarity_flip = 1'b0; polarity_write = 1'b0;
		output_signal_select = 4'h0; select_write = 1'b0; pulse_high_len = 32'h0;
		pulse_cycle_len = 32'h0; burst_count = 17'h0; generator_run_style = 1'b0;
		generator_on = 1'b0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		cyc(1);
		chk("output_line_a", 0, output_line_a);
		chk("select_readback", 0, select_readback);
		$display("test reset done");

		// each source code 1..9 except the generator (7) on output a; other events must not leak through
		for (int c = 1; c <= 9; c++)
		begin
			if (c == 7)
				continue;
			set_line(PICK_OUTPUT_A, 4'(c), 1'b0);
			chk("select_readback", 32'(c), select_readback);
			m = 8'h01 << (c <= 6 ? 8 - c : 9 - c);
			// all other events high first, then only the chosen one; one cycle latency
			@(posedge clk);
			events <= event_bus_t'(~m);
			@(posedge clk);
			events <= event_bus_t'(m);
			#1;
			chk("output_line_a idle", 0, output_line_a);
			@(posedge clk);
			events <= '0;
			#1;
			chk("output_line_a pulse", 1, output_line_a);
			cyc(1);
			chk("output_line_a after", 0, output_line_a);
		end
		$display("test routing done");

		set_line(PICK_OUTPUT_A, 4'hA, 1'b0);
		chk("select_readback kept", 9, select_readback);
		set_line(PICK_INPUT_A, SRC_TRIG_RAW, 1'b1);
		chk("select_readback input", 0, select_readback);
		chk("direction input", 0, direction_indicator);
		chk("polarity_readback", 1, polarity_readback);
		chk("input_line_a inverted", 1, input_line_a);
		@(posedge clk);
		ext_level_a <= 1'b1;
		cyc(4);
		chk("input_line_a inverted", 0, input_line_a);
		set_line(PICK_OUTPUT_B, SRC_OFF, 1'b1);
		chk("output_line_b off inverted", 1, output_line_b);
		chk("direction output", 1, direction_indicator);
		chk("level_readback output", 1, level_readback);
		set_line(PICK_INPUT_B, SRC_OFF, 1'b0);
		chk("input_line_b loop", 1, input_line_b);
		chk("level_readback input", 1, level_readback);
		$display("test lines done");

		// counted bursts, twice to see the rearm
		set_line(PICK_OUTPUT_A, SRC_GENERATOR, 1'b0);
		for (int k = 0; k < 2; k++)
		begin
			gen_start(2'h0, 2, 5, 3, STYLE_COUNTED);
			measure(40);
			chk("burst pulses", 3, rises);
			chk("burst high cycles", 6, highs);
			chk("output_line_a pulses", 3, out_rises);
			chk("generator_running", 0, generator_running);
		end
		gen_start(2'h0, 2, 5, 1, STYLE_CONTINUOUS);
		measure(45);
		chk("continuous pulses", 9, rises);
		chk("continuous period", 5, gap);
		@(posedge clk);
		generator_on <= 1'b0;
		cyc(3);
		measure(20);
		chk("pulses while off", 0, rises);
		$display("test generator done");

		// time base codes: width and period of a full pulse scale with the tick
		for (int s = 0; s < 4; s++)
		begin
			f = (s == 0) ? SCALE_FACTOR_1 : (s == 1) ? SCALE_FACTOR_10 :
				(s == 2) ? SCALE_FACTOR_100 : SCALE_FACTOR_1K;
			f = f * CYC;
			gen_start(2'(s), 1, 2, 3, STYLE_COUNTED);
			measure(6 * f + 40);
			chk("scaled period", 32'(2 * f), gap);
			chk("scaled width", 32'(f), run_len);
		end
		$display("test time base done");
		final_report();
	end
endmodule

/* tick_divider.sv */
`timescale 1ns/1ps
module tick_divider
	import line_pkg::*;
#(
	parameter int CYCLES = CYCLES_PER_US
)(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// time base
	input  wire logic [1:0] tick_scale,
	output logic            tick
);

	initial if (CYCLES < 1) $error("tick_divider: CYCLES must be at least one");

	logic [$clog2(CYCLES+1)-1:0] us_cnt;
	logic [9:0]                  scale_cnt;
	logic [9:0]                  scale_top;
	logic                        us_pulse;

	// microsecond enable pulse
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			us_cnt   <= '0;
			us_pulse <= 1'b0;
		end
		else
		begin
			us_pulse <= (us_cnt == $bits(us_cnt)'(CYCLES - 1));
			us_cnt   <= (us_cnt == $bits(us_cnt)'(CYCLES - 1)) ? '0 : us_cnt + 1'b1;
		end
	end

	// multiplier per scale code
	always_comb
	begin
		case (tick_scale)
			2'h0:    scale_top = 10'(SCALE_FACTOR_1 - 1);
			2'h1:    scale_top = 10'(SCALE_FACTOR_10 - 1);
			2'h2:    scale_top = 10'(SCALE_FACTOR_100 - 1);
			default: scale_top = 10'(SCALE_FACTOR_1K - 1);
		endcase
	end

	// scaled tick; a scale change applies at the next microsecond pulse, the count running on against the new top
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			scale_cnt <= '0;
			tick      <= 1'b0;
		end
		else
		begin
			tick <= 1'b0;
			if (us_pulse)
			begin
				if (scale_cnt >= scale_top)
				begin
					scale_cnt <= '0;
					tick      <= 1'b1; // [R12]
				end
				else
					scale_cnt <= scale_cnt + 1'b1;
			end
		end
	end

endmodule
